// [hw_config_pkg.sv]
// Purpose: Shared constants and types for the hardware configuration block.
// Assumes: APB slave with 32-bit data; one register at byte offset 0x010.
// Notes: Lower byte of the register is outside this block and reads zero.
package hw_config_pkg;

  // Register offset, byte address.
  localparam logic [11:0] HW_CONFIG_OFFSET = 12'h010;

  // Field positions inside the register.
  localparam int INDICATOR_LSB = 20;
  localparam int STATUS_BIT = 15;
  localparam int DETACH_BIT = 14;
  localparam int SOURCE_BIT = 13;
  localparam int PROTECT_BIT = 12;
  localparam int BUFFER_BIT = 10;
  localparam int ATTACH_EN_BIT = 9;
  localparam int POLARITY_BIT = 8;

  // Values after power-on reset.
  localparam logic [3:0] INDICATOR_RESET = 4'h0;
  localparam logic SOURCE_RESET = 1'b0;
  localparam logic PROTECT_RESET = 1'b0;
  localparam logic BUFFER_RESET = 1'b0;
  localparam logic ATTACH_EN_RESET = 1'b0;
  localparam logic POLARITY_RESET = 1'b0;

  // Fields that survive lighter resets while protection is set.
  typedef struct packed {
    logic [3:0] indicator_enable;
    logic descriptor_source_select;
    logic protect;
    logic buffer_push_pull;
    logic attach_enable;
    logic attach_pin_polarity;
  } protected_cfg_t;

  // Attach pin as two signals.
  typedef struct packed {
    logic value;
    logic enable;
  } pin_drive_t;

  // Detach sequencer states.
  typedef enum logic [1:0] {
    ATTACHED,
    DETACHED,
    REATTACH
  } attach_state_t;

endpackage

// [hw_config_attach_control.sv]
// Purpose: Upper three bytes of the hardware configuration register with detach.
// Assumes: Link and wake inputs are asynchronous and synchronised here.
// Notes: reset is power-on; lite_reset is any lighter reset.
// How it works
// - Bits 23:20 enable four indicator pin functions.
// - Protect bit keeps fields through non-power-on resets.
// - Bit 15 shows a detach event occurred.
// - Writing bit 14 detaches device from USB.
// - Link or wake reattaches and sets status.
// - Bit 13 picks descriptor source without config.
// - Source bit ignored when EEPROM or OTP present.
// - Bit 10 picks open-drain or push-pull driver.
// - Bit 9 drives attach pin while attaching.
// - Attach pin also asserts on detach reattachment.
// - Bit 8 sets attach pin active level.
// - Attach pin settings matter only in HSIC.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module hw_config_attach_control
  import hw_config_pkg::*;
(
  // Clock and resets.
  input wire logic clock,
  input wire logic reset,
  input wire logic lite_reset,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device status inputs.
  input wire logic link_up,
  input wire logic gpio_wake,
  input wire logic usb_attempting_attach,
  input wire logic hsic_mode,
  input wire logic eeprom_present,
  input wire logic otp_configured,
  // Outputs to the rest of the device.
  output logic [3:0] indicator_enable,
  output logic use_descriptor_ram,
  output logic usb_detached,
  output logic attach_pin_out,
  output logic attach_pin_oe
);

  // Stored configuration fields.
  protected_cfg_t cfg;
  // Sticky detach status flag.
  logic detach_event_status;
  // Detach request bit, self-clearing.
  logic detach_request;
  // Detach sequencer state.
  attach_state_t state;
  // Synchronisers for pin inputs.
  logic [1:0] link_sync;
  logic [1:0] wake_sync;
  logic [1:0] attempt_sync;
  // Decoded access strobes.
  logic hit;
  logic wr_en;
  // Drive of the attach pin.
  pin_drive_t pin;
  logic attach_active;

  // Every access completes in its first access cycle, no wait states.
  assign pready = 1'b1;
  assign hit = (paddr == HW_CONFIG_OFFSET);
  // Unmapped addresses answer with an error rather than silently.
  assign pslverr = psel && penable && !hit;
  assign wr_en = psel && penable && pwrite && hit;

  // Two flops before anything looks at the asynchronous inputs.
  always_ff @(posedge clock) begin
    if (reset) begin
      link_sync <= 2'h0;
      wake_sync <= 2'h0;
      attempt_sync <= 2'h0;
    end else begin
      link_sync <= {link_sync[0], link_up};
      wake_sync <= {wake_sync[0], gpio_wake};
      attempt_sync <= {attempt_sync[0], usb_attempting_attach};
    end
  end

  // Configuration fields; lighter resets spare them while protected.
  always_ff @(posedge clock) begin
    if (reset) begin
      cfg.indicator_enable <= INDICATOR_RESET;
      cfg.descriptor_source_select <= SOURCE_RESET;
      cfg.protect <= PROTECT_RESET;
      cfg.buffer_push_pull <= BUFFER_RESET;
      cfg.attach_enable <= ATTACH_EN_RESET;
      cfg.attach_pin_polarity <= POLARITY_RESET;
    end else if (lite_reset && !cfg.protect) begin
      // Unprotected lighter reset restores defaults.
      cfg.indicator_enable <= INDICATOR_RESET;
      cfg.descriptor_source_select <= SOURCE_RESET;
      cfg.protect <= PROTECT_RESET;
      cfg.buffer_push_pull <= BUFFER_RESET;
      cfg.attach_enable <= ATTACH_EN_RESET;
      cfg.attach_pin_polarity <= POLARITY_RESET;
    end else if (wr_en && !lite_reset) begin
      cfg.indicator_enable <= pwdata[INDICATOR_LSB +: 4];
      cfg.descriptor_source_select <= pwdata[SOURCE_BIT];
      cfg.protect <= pwdata[PROTECT_BIT];
      cfg.buffer_push_pull <= pwdata[BUFFER_BIT];
      cfg.attach_enable <= pwdata[ATTACH_EN_BIT];
      cfg.attach_pin_polarity <= pwdata[POLARITY_BIT];
    end
  end

  // Detach request: set by a write, cleared once the detach is taken.
  always_ff @(posedge clock) begin
    if (reset || lite_reset) begin
      detach_request <= 1'b0;
    end else if (wr_en && pwdata[DETACH_BIT]) begin
      detach_request <= 1'b1;
    end else if (state == DETACHED) begin
      detach_request <= 1'b0;
    end
  end

  // Detach sequencer: off the bus until link or wake.
  always_ff @(posedge clock) begin
    if (reset || lite_reset) begin
      state <= ATTACHED;
    end else begin
      case (state)
        ATTACHED: begin
          if (detach_request) begin
            state <= DETACHED;
          end
        end
        DETACHED: begin
          if (link_sync[1] || wake_sync[1]) begin
            state <= REATTACH;
          end
        end
        default: begin
          state <= ATTACHED;
        end
      endcase
    end
  end

  // Status flag: set wins over a clearing write in the same cycle.
  always_ff @(posedge clock) begin
    if (reset || lite_reset) begin
      detach_event_status <= 1'b0;
    end else if (state == REATTACH) begin
      detach_event_status <= 1'b1;
    end else if (wr_en && pwdata[STATUS_BIT]) begin
      detach_event_status <= 1'b0;
    end
  end

  // Read data registered during setup so it is stable in the access phase.
  always_ff @(posedge clock) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && hit && !pwrite) begin
      prdata <= 32'h0000_0000;
      prdata[INDICATOR_LSB +: 4] <= cfg.indicator_enable;
      prdata[STATUS_BIT] <= detach_event_status;
      prdata[DETACH_BIT] <= detach_request;
      prdata[SOURCE_BIT] <= cfg.descriptor_source_select;
      prdata[PROTECT_BIT] <= cfg.protect;
      prdata[BUFFER_BIT] <= cfg.buffer_push_pull;
      prdata[ATTACH_EN_BIT] <= cfg.attach_enable;
      prdata[POLARITY_BIT] <= cfg.attach_pin_polarity;
    end
  end

  // Outputs to the device; held in flops for clean timing.
  always_ff @(posedge clock) begin
    if (reset) begin
      indicator_enable <= INDICATOR_RESET;
      use_descriptor_ram <= 1'b0;
      usb_detached <= 1'b0;
    end else begin
      indicator_enable <= cfg.indicator_enable;
      // The source bit only counts when no external image exists.
      use_descriptor_ram <= cfg.descriptor_source_select &&
        !eeprom_present && !otp_configured;
      usb_detached <= (state == DETACHED);
    end
  end

  // Attach pin: active while attaching or reattaching, HSIC only.
  assign attach_active = hsic_mode && cfg.attach_enable &&
    (attempt_sync[1] || state == REATTACH);

  always_comb begin
    // Active level follows polarity; open-drain only pulls low.
    pin.value = attach_active ? cfg.attach_pin_polarity
                              : !cfg.attach_pin_polarity;
    if (cfg.buffer_push_pull) begin
      pin.enable = hsic_mode && cfg.attach_enable;
    end else begin
      pin.enable = hsic_mode && cfg.attach_enable && !pin.value;
    end
  end

  // Pin outputs registered so the pad sees no glitches.
  always_ff @(posedge clock) begin
    if (reset) begin
      attach_pin_out <= 1'b0;
      attach_pin_oe <= 1'b0;
    end else begin
      attach_pin_out <= pin.value;
      attach_pin_oe <= pin.enable;
    end
  end

  // Assertions guard the rules of this side; each names its rule.
  // Power-on reset disables all but protect_por_a, since all state is rebuilt then.
  status_set_a: assert property (@(posedge clock)
    disable iff (reset)
    state == REATTACH && !lite_reset |=> detach_event_status)
    else $error("status not set on reattach");
  request_clear_a: assert property (@(posedge clock)
    disable iff (reset || lite_reset)
    state == DETACHED |=> !detach_request)
    else $error("detach request did not clear");
  detach_go_a: assert property (@(posedge clock)
    disable iff (reset || lite_reset)
    detach_request && state == ATTACHED |=> ##1 usb_detached)
    else $error("device did not detach");
  protect_hold_a: assert property (@(posedge clock)
    disable iff (reset)
    lite_reset && cfg.protect |=> $stable(cfg))
    else $error("protected fields changed");
  protect_por_a: assert property (@(posedge clock)
    reset |=> !cfg.protect)
    else $error("protect not cleared by power-on");
  source_gate_a: assert property (@(posedge clock)
    disable iff (reset)
    (eeprom_present || otp_configured) |=> !use_descriptor_ram)
    else $error("source bit used with image present");
  hsic_gate_a: assert property (@(posedge clock)
    disable iff (reset)
    !hsic_mode |=> !attach_pin_oe)
    else $error("attach pin driven outside HSIC");
  drain_only_a: assert property (@(posedge clock)
    disable iff (reset)
    attach_pin_oe && !cfg.buffer_push_pull && $stable(cfg)
    |-> !attach_pin_out)
    else $error("open drain drove high");
  read_zero_a: assert property (@(posedge clock)
    disable iff (reset)
    1'b1 |-> prdata[31:24] == 8'h00 && prdata[19:16] == 4'h0 &&
      prdata[11] == 1'b0)
    else $error("reserved bits read nonzero");
  indicator_a: assert property (@(posedge clock)
    disable iff (reset)
    1'b1 |=> indicator_enable == $past(cfg.indicator_enable))
    else $error("indicator enables not forwarded");
  // A read setup must capture live fields, or software sees stale data.
  read_load_a: assert property (@(posedge clock)
    disable iff (reset)
    psel && !penable && hit && !pwrite
    |=> prdata[STATUS_BIT] == $past(detach_event_status) &&
      prdata[PROTECT_BIT] == $past(cfg.protect))
    else $error("read data not taken from fields");
  status_clear_a: assert property (@(posedge clock)
    disable iff (reset || lite_reset)
    wr_en && pwdata[STATUS_BIT] && state != REATTACH
    |=> !detach_event_status)
    else $error("status not cleared by write of one");
  write_take_a: assert property (@(posedge clock)
    disable iff (reset)
    wr_en && !lite_reset
    |=> cfg.indicator_enable == $past(pwdata[INDICATOR_LSB +: 4]))
    else $error("indicator enables not written");
  stay_detached_a: assert property (@(posedge clock)
    disable iff (reset || lite_reset)
    state == DETACHED && !link_sync[1] && !wake_sync[1]
    |=> state == DETACHED)
    else $error("left detached state without wake");
  reattach_pin_a: assert property (@(posedge clock)
    disable iff (reset)
    state == REATTACH && hsic_mode && cfg.attach_enable
    |=> attach_pin_out == $past(cfg.attach_pin_polarity))
    else $error("attach pin idle during reattach");

  // Cover the main scenarios, so a quiet run cannot pass unnoticed.
  // The detach cycle needs a wake within a short window of the bench.
  detach_cycle_c: cover property (@(posedge clock) disable iff (reset)
    state == DETACHED ##[1:50] state == REATTACH);
  status_clear_c: cover property (@(posedge clock) disable iff (reset)
    detach_event_status ##1 !detach_event_status);
  protect_c: cover property (@(posedge clock) disable iff (reset)
    lite_reset && cfg.protect);
  reattach_pin_c: cover property (@(posedge clock) disable iff (reset)
    state == REATTACH ##1 attach_pin_oe && attach_pin_out);
  unmapped_c: cover property (@(posedge clock) disable iff (reset)
    pslverr);

endmodule

// [hw_config_attach_control_test.sv]
// Purpose: Self-checking bench for the hardware configuration block.
// Assumes: Zero-wait APB slave; outputs settle within a few clocks.
// Notes: A shadow word tracks what software should read back.
`timescale 1ns/1ps
module hw_config_attach_control_test;
  import hw_config_pkg::*;
  // Clock, resets and APB request.
  logic clock = 0, reset = 1, lite_reset = 0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  // Device side inputs and outputs.
  logic link_up = 0, gpio_wake = 0, usb_attempting_attach = 0;
  logic hsic_mode = 0, eeprom_present = 0, otp_configured = 0;
  logic [3:0] indicator_enable;
  logic use_descriptor_ram, usb_detached, attach_pin_out, attach_pin_oe;
  // Shadow register, seed, counters and scratch.
  logic [31:0] m = 32'h0, s = 32'h11, rd;
  logic err, seen, act, val, oe_exp;
  int error_cnt = 0, n_compared = 0;
  localparam logic [31:0] RW = 32'h00F0_3700; // Plain read/write fields.

  always #25 clock = ~clock;

  hw_config_attach_control u_dut (.clock(clock), .reset(reset),
    .lite_reset(lite_reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_up(link_up),
    .gpio_wake(gpio_wake), .usb_attempting_attach(usb_attempting_attach),
    .hsic_mode(hsic_mode), .eeprom_present(eeprom_present),
    .otp_configured(otp_configured), .indicator_enable(indicator_enable),
    .use_descriptor_ram(use_descriptor_ram), .usb_detached(usb_detached),
    .attach_pin_out(attach_pin_out), .attach_pin_oe(attach_pin_oe));

  // Galois shift register; the taps give a long cycle from any nonzero seed.
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return v[0] ? ((v >> 1) ^ 32'h8020_0003) : (v >> 1);
  endfunction

  // Prints the counts and the verdict, then stops the run.
  task automatic conclude;
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // One comparison of a 32-bit result against the model.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    int i;
    @(posedge clock);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge clock);
    penable <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (i == 20) begin
      error_cnt++;
      conclude();
    end
  endtask

  // Write the register and fold the write into the shadow word.
  task automatic wr(input logic [31:0] wd);
    apb(1, HW_CONFIG_OFFSET, wd);
    m = (m & ~RW) | (wd & RW);
    if (wd[15]) m[15] = 1'b0;
  endtask

  // Bounded wait for the detached level, noting any attach pulse.
  task automatic wait_det(input logic lvl);
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge clock);
      if (attach_pin_out === 1'b1) seen = 1'b1;
      if (usb_detached === lvl) break;
    end
    repeat (4) @(posedge clock) if (attach_pin_out === 1'b1) seen = 1'b1;
    if (i == 40) begin
      error_cnt++;
      conclude();
    end
  endtask

  initial begin
    repeat (20) @(posedge clock);
    reset <= 0;
    apb(0, HW_CONFIG_OFFSET, 0); chk(rd, 0);
    apb(1, 12'h014, 32'hFFFF_FFFF); chk({31'h0, err}, 1);
    apb(0, HW_CONFIG_OFFSET, 0); chk(rd, m);
    // Random configurations, reserved bits included in the write data.
    repeat (8) begin
      s = lfsr(s);
      wr(s & ~32'h0000_4000);
      apb(0, HW_CONFIG_OFFSET, 0); chk(rd, m);
      chk({28'h0, indicator_enable}, {28'h0, m[23:20]});
      for (int k = 0; k < 4; k++) begin
        eeprom_present <= k[0]; otp_configured <= k[1];
        repeat (3) @(posedge clock);
        chk({31'h0, use_descriptor_ram}, {31'h0, m[13] & (k == 0)});
      end
    end
    // Protected fields survive a lighter reset, not a power-on one.
    wr(RW); lite_reset <= 1; @(posedge clock); lite_reset <= 0;
    apb(0, HW_CONFIG_OFFSET, 0); chk(rd, m);
    wr(32'h00A0_2500); lite_reset <= 1; @(posedge clock); lite_reset <= 0;
    m = 0; apb(0, HW_CONFIG_OFFSET, 0); chk(rd, m);
    wr(RW); reset <= 1; repeat (2) @(posedge clock); reset <= 0;
    m = 0; apb(0, HW_CONFIG_OFFSET, 0); chk(rd, m);
    // Attach pin over polarity, buffer, enable, mode and attempt.
    for (int k = 0; k < 32; k++) begin
      wr({21'h0, k[2:0], 8'h00});
      hsic_mode <= k[3]; usb_attempting_attach <= k[4];
      repeat (6) @(posedge clock);
      act = k[1] & k[3] & k[4];
      val = act ? k[0] : ~k[0];
      // Outside HSIC or with the pin disabled nothing drives it.
      oe_exp = k[3] & k[1] & (k[2] | ~val);
      chk({30'h0, attach_pin_out, attach_pin_oe}, {30'h0, val, oe_exp});
    end
    // Detach, wake from link then from the wake pin, clear status.
    usb_attempting_attach <= 0; hsic_mode <= 1;
    for (int k = 0; k < 2; k++) begin
      wr(32'h0000_4700); seen = 0; wait_det(1);
      apb(0, HW_CONFIG_OFFSET, 0); chk(rd, m);
      if (k == 0) link_up <= 1; else gpio_wake <= 1;
      wait_det(0); m[15] = 1; chk({31'h0, seen}, 1);
      link_up <= 0; gpio_wake <= 0;
      apb(0, HW_CONFIG_OFFSET, 0); chk(rd, m);
      wr(m); apb(0, HW_CONFIG_OFFSET, 0); chk(rd, m);
    end
    conclude();
  end
endmodule
